// ==== verilog/xcvr_consts.svh ====
// constants for the registered bus transceiver: offsets, fields, resets
// Overview of operation
// RULE1: Data passed between port A and port B, live or stored, is never inverted.
// RULE2: A rising edge of the A-to-B capture clock loads port A into the A-side store, and the B-to-A clock loads port B into the B-side store.
// RULE3: Without a rising capture edge, both stores keep their contents whatever the other controls do.
// RULE4: Capture is never gated by the output enable or the direction control.
// RULE5: The active-low output enable and the direction control decide which port drives, and with the enable high neither port drives.
// RULE6: With the enable low, direction high drives port B from A, and direction low drives port A from B.
// RULE7: In isolation both ports are inputs while either store may still capture.
// RULE8: Each source select picks live opposite-port data when low and the stored word when high.
// RULE9: In transceiver mode the input port may be stored into either store or both.
// RULE10: The outside logic drives only the ports that are inputs, one port when enabled and both in isolation.
// RULE11: The stores have no reset and hold unknown data until their first capture edge.
`ifndef XCVR_CONSTS_SVH
`define XCVR_CONSTS_SVH

// register byte offsets
`define CTRL_OFFSET 4'h0
`define STORE_OFFSET 4'h4
`define LOG_OFFSET 4'h8
`define LOG_STAT_OFFSET 4'hC

// control register fields
`define CTRL_OE_N_BIT 0
`define CTRL_DIR_BIT 1
`define CTRL_B_SRC_BIT 2
`define CTRL_A_SRC_BIT 3

// store and log fields
`define STORE_B_LSB 8
`define LOG_VALID_BIT 31
`define LOG_STAT_READY_BIT 31

// reset values: isolation, live data on both paths
`define CTRL_OE_N_RESET 1'b1
`define CTRL_DIR_RESET 1'b0
`define CTRL_SRC_RESET 1'b0

// fifo depth in words
`define LOG_DEPTH 16

`endif

// ==== verilog/xcvr_pkg.sv ====
// types shared by the registered bus transceiver
package xcvr_pkg;

  // control bits steering the port drivers
  typedef struct packed {
    logic a_port_source_select;
    logic b_port_source_select;
    logic dir;
    logic oe_n;
  } ctrl_s;

endpackage : xcvr_pkg

// ==== verilog/registered_transceiver.sv ====
// registered bus transceiver with capture log fifo and avalon-mm registers
`timescale 1ns/100ps
`include "xcvr_consts.svh"

////////////////////////////////////////////////////////////////////////////
// simple synchronous fifo, one push and one pop per cycle
module capture_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  // pointers wrap on their own, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_s;

  fifo_state_s q;
  fifo_state_s next_q;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  logic full;
  logic empty;

  // handshakes on both sides; full and empty follow the count
  assign full = (q.count == (AW+1)'(DEPTH));
  assign empty = (q.count == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[q.rd_ptr];
  assign count = q.count;

  // pointer and count update
  always_comb begin
    next_q = q;
    if (push) begin
      next_q.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_q.rd_ptr = q.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10: next_q.count = q.count + 1'b1;
      2'b01: next_q.count = q.count - 1'b1;
      default: next_q.count = q.count;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // storage carries no reset, it is only read behind valid
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[q.wr_ptr] <= in_data;
    end
  end

endmodule : capture_fifo

////////////////////////////////////////////////////////////////////////////
// the transceiver proper
module registered_transceiver
  import xcvr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int LOG_DEPTH = `LOG_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // capture clocks, sampled on sys_clk
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  // two-way port a
  input wire logic [WIDTH-1:0] port_a_lines_in,
  output logic [WIDTH-1:0] port_a_lines_out,
  output logic port_a_lines_oe,
  // two-way port b
  input wire logic [WIDTH-1:0] port_b_lines_in,
  output logic [WIDTH-1:0] port_b_lines_out,
  output logic port_b_lines_oe,
  // capture log has room
  output logic capture_log_ready
);
  // log entry: both edge flags and both port words
  localparam int EW = 2 * WIDTH + 2;
  localparam int CW = $clog2(LOG_DEPTH) + 1;

  typedef struct packed {
    ctrl_s ctrl;
    logic [WIDTH-1:0] a_side_store;
    logic [WIDTH-1:0] b_side_store;
    logic cab_prev;
    logic cba_prev;
    logic [WIDTH-1:0] port_a_out;
    logic [WIDTH-1:0] port_b_out;
    logic a_oe;
    logic b_oe;
    logic waitrequest;
    logic [31:0] readdata;
    logic push;
    logic [EW-1:0] push_data;
    logic pop;
    logic log_ready;
  } xcvr_state_s;

  xcvr_state_s q;
  xcvr_state_s next_q;
  // edge detect and bus handshake
  logic cab_rise;
  logic cba_rise;
  logic take;
  logic commit;
  // log fifo wiring
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [EW-1:0] fifo_out_data;
  logic [CW-1:0] fifo_count;

  ////////////////////////////////////////////////////////////////////////////
  // capture history; a full log drops entries but never blocks a capture
  capture_fifo #(
    .WIDTH(EW),
    .DEPTH(LOG_DEPTH)
  ) capture_fifo_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(q.push),
    .in_ready(fifo_in_ready),
    .in_data(q.push_data),
    .out_valid(fifo_out_valid),
    .out_ready(q.pop),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // rising edges of the capture clocks
  assign cab_rise = a_to_b_capture_clock && !q.cab_prev;
  assign cba_rise = b_to_a_capture_clock && !q.cba_prev;
  // a bus request is answered one cycle after it is first seen
  assign take = (read || write) && q.waitrequest;
  // the answer cycle, where a held write is committed
  assign commit = (read || write) && !q.waitrequest;

  ////////////////////////////////////////////////////////////////////////////
  // next state: captures, port drivers, capture log and bus slave
  always_comb begin
    next_q = q;

    // capture clock history for the edge detectors
    next_q.cab_prev = a_to_b_capture_clock;
    next_q.cba_prev = b_to_a_capture_clock;

    // stores load only on their own edge, independent of oe_n and dir
    if (cab_rise) begin
      next_q.a_side_store = port_a_lines_in; // RULE2 RULE4 RULE7 RULE9
    end
    if (cba_rise) begin
      next_q.b_side_store = port_b_lines_in; // RULE2 RULE4 RULE7 RULE9
    end
    // otherwise the stores keep their value through next_q = q  RULE3

    // log every capture edge with both words
    next_q.push = cab_rise || cba_rise;
    next_q.push_data = {cba_rise, cab_rise, port_b_lines_in, port_a_lines_in};
    // one cycle late, good enough for software polling
    next_q.log_ready = fifo_in_ready;

    // port b data: live port a or the a-side store, never inverted
    if (q.ctrl.b_port_source_select) begin
      next_q.port_b_out = q.a_side_store; // RULE1 RULE8
    end else begin
      next_q.port_b_out = port_a_lines_in; // RULE1 RULE8
    end
    // port a data: live port b or the b-side store, never inverted
    if (q.ctrl.a_port_source_select) begin
      next_q.port_a_out = q.b_side_store; // RULE1 RULE8
    end else begin
      next_q.port_a_out = port_b_lines_in; // RULE1 RULE8
    end

    // drivers: one port at most, none while disabled
    next_q.a_oe = 1'b0; // RULE5
    next_q.b_oe = 1'b0; // RULE5
    if (!q.ctrl.oe_n) begin
      if (q.ctrl.dir) begin
        next_q.b_oe = 1'b1; // RULE6
      end else begin
        next_q.a_oe = 1'b1; // RULE6
      end
    end

    // bus slave: one wait cycle, then the answer for one cycle
    next_q.waitrequest = !take;
    next_q.pop = 1'b0;
    // a write lands at the edge that ends its answer cycle
    if (commit && write && (address == `CTRL_OFFSET) && byteenable[0]) begin
      next_q.ctrl.oe_n = writedata[`CTRL_OE_N_BIT];
      next_q.ctrl.dir = writedata[`CTRL_DIR_BIT];
      next_q.ctrl.b_port_source_select = writedata[`CTRL_B_SRC_BIT];
      next_q.ctrl.a_port_source_select = writedata[`CTRL_A_SRC_BIT];
    end
    // read data is fetched as the request is taken, so it stands next cycle
    if (take && read) begin
      next_q.readdata = 32'h0000_0000;
      case (address)
        `CTRL_OFFSET: begin
          next_q.readdata[`CTRL_OE_N_BIT] = q.ctrl.oe_n;
          next_q.readdata[`CTRL_DIR_BIT] = q.ctrl.dir;
          next_q.readdata[`CTRL_B_SRC_BIT] = q.ctrl.b_port_source_select;
          next_q.readdata[`CTRL_A_SRC_BIT] = q.ctrl.a_port_source_select;
        end
        `STORE_OFFSET: begin
          next_q.readdata[WIDTH-1:0] = q.a_side_store;
          next_q.readdata[`STORE_B_LSB +: WIDTH] = q.b_side_store;
        end
        `LOG_OFFSET: begin
          // an empty log reads with the valid bit low and pops nothing
          next_q.readdata[EW-1:0] = fifo_out_data;
          next_q.readdata[`LOG_VALID_BIT] = fifo_out_valid;
          next_q.pop = fifo_out_valid;
        end
        `LOG_STAT_OFFSET: begin
          next_q.readdata[CW-1:0] = fifo_count;
          next_q.readdata[`LOG_STAT_READY_BIT] = fifo_in_ready;
        end
        default: begin
          next_q.readdata = 32'h0000_0000; // unmapped reads as zero
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stores are left out of the reset branch so they power up unknown
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // control comes up isolated with live data selected
      q.ctrl.oe_n <= `CTRL_OE_N_RESET;
      q.ctrl.dir <= `CTRL_DIR_RESET;
      q.ctrl.b_port_source_select <= `CTRL_SRC_RESET;
      q.ctrl.a_port_source_select <= `CTRL_SRC_RESET;
      // history reads high, so a clock held high at release is no edge
      q.cab_prev <= 1'b1;
      q.cba_prev <= 1'b1;
      // both ports released
      q.port_a_out <= '0;
      q.port_b_out <= '0;
      q.a_oe <= 1'b0;
      q.b_oe <= 1'b0;
      // bus slave waiting, log idle
      q.waitrequest <= 1'b1;
      q.readdata <= 32'h0000_0000;
      q.push <= 1'b0;
      q.push_data <= '0;
      q.pop <= 1'b0;
      q.log_ready <= 1'b0;
    end else begin
      q <= next_q; // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave outputs, straight from the state flops
  assign readdata = q.readdata;
  assign waitrequest = q.waitrequest;

  // port drivers
  assign port_a_lines_out = q.port_a_out;
  assign port_a_lines_oe = q.a_oe;
  assign port_b_lines_out = q.port_b_out;
  assign port_b_lines_oe = q.b_oe;

  // log status
  assign capture_log_ready = q.log_ready;

endmodule : registered_transceiver

// ==== tb/xcvr_chk_assertions.sv ====
// port checker for the registered transceiver
`timescale 1ns/100ps
module xcvr_chk
  import xcvr_pkg::*;
#(parameter int WIDTH = 8) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  input wire logic [WIDTH-1:0] port_a_lines_in,
  input wire logic [WIDTH-1:0] port_a_lines_out,
  input wire logic port_a_lines_oe,
  input wire logic [WIDTH-1:0] port_b_lines_in,
  input wire logic [WIDTH-1:0] port_b_lines_out,
  input wire logic port_b_lines_oe
);
  ctrl_s cs;
  logic pa, pb;
  logic [WIDTH-1:0] sa, sb;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // shadow control word and capture clock history
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cs <= ctrl_s'(4'h1);
      pa <= 1'b1;
      pb <= 1'b1;
    end else begin
      if (write && !waitrequest && address == 4'h0 && byteenable[0])
        cs <= ctrl_s'(writedata[3:0]);
      pa <= a_to_b_capture_clock;
      pb <= b_to_a_capture_clock;
    end
  end
  // reference stores, no reset, as in the part
  always_ff @(posedge sys_clk) begin
    if (a_to_b_capture_clock && !pa)
      sa <= port_a_lines_in;
    if (b_to_a_capture_clock && !pb)
      sb <= port_b_lines_in;
  end
  sequence s_store;
    !waitrequest && readdata[15:0] == {$past(sb), $past(sa)} ##1 waitrequest;
  endsequence
  AST_ONE_DRIVER:
    assert property (!(port_a_lines_oe && port_b_lines_oe))
    else $error("both ports driven");
  AST_ISOLATE:
    assert property ($past(cs.oe_n) |-> !port_a_lines_oe && !port_b_lines_oe)
    else $error("port driven in isolation");
  AST_DRIVE_B:
    assert property ($past(!cs.oe_n && cs.dir) |-> port_b_lines_oe)
    else $error("port b not driven");
  AST_DRIVE_A:
    assert property ($past(!cs.oe_n && !cs.dir) |-> port_a_lines_oe)
    else $error("port a not driven");
  AST_LIVE_B:
    assert property ($past(cs.dir && !cs.b_port_source_select) |->
      port_b_lines_out == $past(port_a_lines_in)) else $error("live b bad");
  AST_KEPT_B:
    assert property ($past(cs.dir && cs.b_port_source_select) |->
      port_b_lines_out == $past(sa)) else $error("stored b bad");
  AST_LIVE_A:
    assert property ($past(!cs.dir && !cs.a_port_source_select) |->
      port_a_lines_out == $past(port_b_lines_in)) else $error("live a bad");
  AST_KEPT_A:
    assert property ($past(!cs.dir && cs.a_port_source_select) |->
      port_a_lines_out == $past(sb)) else $error("stored a bad");
  AST_STORE_RD:
    assert property (read && waitrequest && address == 4'h4 |=> s_store)
    else $error("store readback bad");
endmodule : xcvr_chk

bind registered_transceiver xcvr_chk #(.WIDTH(WIDTH)) xcvr_chk_inst (
  .sys_clk, .rstn, .address, .read, .write, .writedata, .byteenable,
  .readdata, .waitrequest, .a_to_b_capture_clock, .b_to_a_capture_clock,
  .port_a_lines_in, .port_a_lines_out, .port_a_lines_oe,
  .port_b_lines_in, .port_b_lines_out, .port_b_lines_oe);

// ==== tb/bus_side.sv ====
// bus logic sitting on both ports of the transceiver
`timescale 1ns/100ps
module bus_side (
  input wire logic [7:0] a_drive,
  input wire logic [7:0] b_drive,
  input wire logic [7:0] a_out,
  input wire logic [7:0] b_out,
  input wire logic a_oe,
  input wire logic b_oe,
  output logic [7:0] a_wire,
  output logic [7:0] b_wire
);
  // outside drivers let go of a port the transceiver drives
  assign a_wire = a_oe ? a_out : a_drive;
  assign b_wire = b_oe ? b_out : b_drive;
endmodule : bus_side

// ==== tb/registered_transceiver_tb_top.sv ====
// self-checking bench for the registered transceiver
`timescale 1ns/100ps
module registered_transceiver_tb_top;
  logic sys_clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
  logic ca = 1'b0, cb = 1'b0, waitrequest, oa, ob, ready;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [7:0] ad = 8'h00, bd = 8'h00, ai, bi, ao, bo, e;
  int failures = 0, samples_checked = 0, cyc = 0;
  registered_transceiver registered_transceiver_inst (.sys_clk, .rstn,
    .address, .read, .write, .writedata, .byteenable(4'hF), .readdata,
    .waitrequest, .a_to_b_capture_clock(ca), .b_to_a_capture_clock(cb),
    .port_a_lines_in(ai), .port_a_lines_out(ao), .port_a_lines_oe(oa),
    .port_b_lines_in(bi), .port_b_lines_out(bo), .port_b_lines_oe(ob),
    .capture_log_ready(ready));
  bus_side bus_side_inst (.a_drive(ad), .b_drive(bd), .a_out(ao),
    .b_out(bo), .a_oe(oa), .b_oe(ob), .a_wire(ai), .b_wire(bi));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic rw, logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    read <= rw;
    write <= !rw;
    address <= a;
    writedata <= d;
    // only the bench timeout ends a wait that never answers
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // one capture clock pulse, then low long enough for the next
  task automatic cap(input logic [7:0] a, b, input logic xa, xb);
    @(posedge sys_clk);
    ad <= a;
    bd <= b;
    ca <= xa;
    cb <= xb;
    @(posedge sys_clk);
    ca <= 1'b0;
    cb <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : cap
  task automatic t_fifo;
    for (int i = 0; i < 17; i++) cap(8'(i), 8'h00, 1'b1, 1'b0);
    chk({29'h0, ready, oa, ob}, 32'h0);
    bus(1'b1, 4'hC, 32'h0);
    chk(rd, 32'h0000_0010);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 4'h8, 32'h0);
      chk(rd & 32'h800300FF, 32'h80010000 | 32'(i));
    end
    bus(1'b1, 4'h8, 32'h0);
    chk({30'h0, rd[31], ready}, 32'h1);
    bus(1'b1, 4'hC, 32'h0);
    chk(rd, 32'h8000_0000);
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_store;
    cap(8'h5A, 8'hA5, 1'b1, 1'b1);
    bus(1'b1, 4'h4, 32'h0);
    chk(rd, 32'h0000A55A);
    bus(1'b0, 4'h0, 32'hE);
    cap(8'h0F, 8'hF0, 1'b0, 1'b0);
    bus(1'b1, 4'h4, 32'h0);
    chk(rd, 32'h0000A55A);
    cap(8'h3C, 8'h00, 1'b1, 1'b0);
    bus(1'b1, 4'h4, 32'h0);
    chk(rd, 32'h0000A53C);
    $display("t_store done");
  endtask : t_store
  task automatic t_ports;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 4'h0, {28'h0, i[1], i[1], i[0], 1'b0});
      cap(8'h66, 8'h99, 1'b0, 1'b0);
      e = i[0] ? (i[1] ? 8'h3C : 8'h66) : (i[1] ? 8'hA5 : 8'h99);
      chk({oa, ob, i[0] ? bo : ao}, {~i[0], i[0], e});
    end
    bus(1'b0, 4'h0, 32'h1);
    bus(1'b1, 4'h2, 32'h0);
    chk(rd, 32'h0);
    chk({oa, ob}, 32'h0);
    $display("t_ports done");
  endtask : t_ports
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_fifo();
    t_store();
    t_ports();
    results();
  end
endmodule : registered_transceiver_tb_top
